// >>> rtl/hw_task_switch_timer.sv
// Time-slice timer and task switch sequencer for up to four tasks
// Behaviour
// RULE_01: Task write during save after underflow switch is ignored; enable write still applies.
// RULE_02: Simultaneous task write and underflow give one switch to the written task.
// RULE_03: Underflow during an instruction-started switch sequence is discarded.
// RULE_04: Software should write task numbers only when no underflow can occur.
// RULE_05: Interrupt suspends current task; same task resumes after the routine.
// RULE_06: Slice timer halts during interrupt service and resumes from held value.
// RULE_07: No task switching while an interrupt is serviced.
// RULE_08: Interrupt stack pointer replaces task stack pointer during interrupt service.
// RULE_09: Slice timer is 8-bit down counter clocked at base clock /16 or /32.
// RULE_10: Underflow switches to next enabled task in ascending order with wrap.
// RULE_11: Disabled tasks are skipped in rotation.
// RULE_12: Timer holds while exactly one task enabled; resumes when more enabled.
// RULE_13: Software should rewrite slice timer before enabling the second task.
// RULE_14: Each switch loads the slice timer with the target task's slice value.
// RULE_15: Clearing slice count enable stops the timer; setting it resumes counting.
// RULE_16: Stopped timer keeps value until a switch or software write reloads it.
// RULE_17: Task writes during interrupt act at return: resume task, then switch.
// RULE_18: Next-task write during interrupt needs no padding instructions.
// RULE_19: Switch sequence takes eleven cycles, then a five-cycle save.
// RULE_20: Writing the next-task field launches a switch immediately.
// RULE_21: If enables of tasks one to three are zero, task zero enable is forced.
// RULE_22: After reset only task zero runs.
// RULE_23: Write and underflow on the same clock edge count as simultaneous.
`timescale 1ns/1ps
module hw_task_switch_timer #(
   parameter int TASKS = task_switch_pkg::TASK_COUNT,
   parameter int SLICE_WIDTH = task_switch_pkg::SLICE_W
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Slice timer configuration
   input wire logic div32_sel_in,
   input wire logic slice_wr_in,
   input wire logic [SLICE_WIDTH-1:0] slice_wdata_in,
   input wire logic slice_value_wr_in,
   input wire logic [task_switch_pkg::TASK_W-1:0] slice_value_idx_in,
   input wire logic [SLICE_WIDTH-1:0] slice_value_wdata_in,
   input wire logic count_en_wr_in,
   input wire logic count_en_wdata_in,
   // Task control writes
   input wire logic enable_wr_in,
   input wire logic [TASKS-1:0] enable_wdata_in,
   input wire logic next_task_wr_in,
   input wire logic [task_switch_pkg::TASK_W-1:0] next_task_wdata_in,
   // CPU interrupt events
   input wire logic irq_enter_in,
   input wire logic irq_return_in,
   // Status
   output logic [task_switch_pkg::TASK_W-1:0] current_task_out,
   output logic [TASKS-1:0] task_run_enable_out,
   output logic slice_count_enable_out,
   output logic [task_switch_pkg::TASK_W-1:0] next_task_select_out,
   output logic [SLICE_WIDTH-1:0] slice_counter_out,
   output logic timer_running_out,
   // Sequencer
   output logic switch_start_out,
   output logic switching_out,
   output logic saving_out,
   // Interrupt context
   output logic irq_active_out,
   output logic irq_stack_sel_out
);
   localparam int TW = task_switch_pkg::TASK_W;

   // ==========================================================
   // Declarations
   task_switch_pkg::seq_state_t state_r;
   logic [task_switch_pkg::CYC_W-1:0] cyc_r;
   logic [SLICE_WIDTH-1:0] slice_value_mem [TASKS];
   logic slice_tick;
   logic pend_valid_r;
   logic by_instr_r;
   logic multi_task;
   logic count_run;
   logic underflow;
   logic irq_block;
   logic seq_idle;
   logic start_fire;
   logic instr_fire;
   logic pend_set;
   logic [TW-1:0] target_task;
   logic [TW-1:0] rotate_task;

   // ==========================================================
   // Helpers
   function automatic logic [TW-1:0] next_enabled(input logic [TW-1:0] cur,
                                                   input logic [TASKS-1:0] en);
      logic [TW-1:0] pick;
      logic found;
      logic [TW-1:0] cand;
      pick = cur;
      found = 1'b0;
      cand = cur;
      for (int i = 1; i < TASKS; i++) begin
         cand = TW'(cur + TW'(i));
         if (!found && en[cand]) begin
            pick = cand;
            found = 1'b1;
         end
      end
      return pick;
   endfunction

   function automatic logic [TASKS-1:0] force_task_zero(input logic [TASKS-1:0] en);
      return {en[TASKS-1:1], en[0] | ~|en[TASKS-1:1]};
   endfunction

   // ==========================================================
   // Slice clock
   slice_prescaler #(
      .DIV_W(task_switch_pkg::PRESCALE_W)
   ) u_prescaler (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .div32_sel_in(div32_sel_in), // RULE_09
      .tick_out(slice_tick)
   );

   // ==========================================================
   // Counting and switch decisions
   assign multi_task = (task_run_enable_out & TASKS'(task_run_enable_out - 1'b1)) != '0;
   assign seq_idle = (state_r == task_switch_pkg::SEQ_IDLE);
   // Counter frozen outside idle, so an underflow cannot land mid-sequence
   assign count_run = multi_task && slice_count_enable_out // RULE_12 RULE_15
                      && !irq_active_out && seq_idle; // RULE_06 RULE_03
   assign underflow = count_run && slice_tick && (slice_counter_out == '0); // RULE_09
   assign irq_block = irq_active_out || irq_enter_in; // RULE_07
   assign instr_fire = seq_idle && !irq_block && (next_task_wr_in || pend_valid_r); // RULE_20 RULE_17
   assign start_fire = instr_fire || (seq_idle && !irq_block && underflow); // RULE_02 RULE_23
   assign pend_set = next_task_wr_in && irq_block; // RULE_18
   assign rotate_task = next_enabled(current_task_out, task_run_enable_out); // RULE_10 RULE_11

   always_comb begin
      if (next_task_wr_in) begin
         target_task = next_task_wdata_in; // RULE_02
      end else if (pend_valid_r) begin
         target_task = next_task_select_out;
      end else begin
         target_task = rotate_task;
      end
   end

   // ==========================================================
   // Per-task slice values
   always_ff @(posedge sys_clk_in) begin
      if (slice_value_wr_in) begin
         slice_value_mem[slice_value_idx_in] <= slice_value_wdata_in;
      end
   end

   // ==========================================================
   // Switch sequencer
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state_r <= task_switch_pkg::SEQ_IDLE;
         cyc_r <= '0;
         switch_start_out <= 1'b0;
         by_instr_r <= 1'b0;
      end else begin
         switch_start_out <= start_fire;
         case (state_r)
            task_switch_pkg::SEQ_IDLE: begin
               cyc_r <= '0;
               if (start_fire) begin
                  state_r <= task_switch_pkg::SEQ_SWITCH;
                  by_instr_r <= instr_fire;
               end
            end
            task_switch_pkg::SEQ_SWITCH: begin
               if (cyc_r == task_switch_pkg::CYC_W'(task_switch_pkg::SWITCH_CYCLES - 1)) begin // RULE_19
                  state_r <= task_switch_pkg::SEQ_SAVE;
                  cyc_r <= '0;
               end else begin
                  cyc_r <= task_switch_pkg::CYC_W'(cyc_r + 1'b1);
               end
            end
            task_switch_pkg::SEQ_SAVE: begin
               // Next-task writes landing here outside interrupt service are dropped; the outgoing set is still being stored
               if (cyc_r == task_switch_pkg::CYC_W'(task_switch_pkg::SAVE_CYCLES - 1)) begin // RULE_19 RULE_01
                  state_r <= task_switch_pkg::SEQ_IDLE;
                  cyc_r <= '0;
               end else begin
                  cyc_r <= task_switch_pkg::CYC_W'(cyc_r + 1'b1);
               end
            end
            default: begin
               state_r <= task_switch_pkg::SEQ_IDLE;
               cyc_r <= '0;
            end
         endcase
      end
   end

   assign switching_out = state_r[1];
   assign saving_out = state_r[2];

   // ==========================================================
   // Current task and next-task selection
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         current_task_out <= task_switch_pkg::TASK_RST; // RULE_22
      end else if (start_fire) begin
         current_task_out <= target_task;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         next_task_select_out <= task_switch_pkg::TASK_RST;
         pend_valid_r <= 1'b0;
      end else if (pend_set) begin
         next_task_select_out <= next_task_wdata_in; // RULE_17
         pend_valid_r <= 1'b1;
      end else if (instr_fire && next_task_wr_in) begin
         next_task_select_out <= next_task_wdata_in; // RULE_20
         pend_valid_r <= 1'b0;
      end else if (start_fire) begin
         pend_valid_r <= 1'b0;
      end
   end

   // ==========================================================
   // Run enables and count enable
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         task_run_enable_out <= task_switch_pkg::RUN_ENABLE_RST; // RULE_22
      end else if (enable_wr_in) begin
         // Applied in every state, including the save window
         task_run_enable_out <= force_task_zero(enable_wdata_in); // RULE_21 RULE_01
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         slice_count_enable_out <= task_switch_pkg::COUNT_ENABLE_RST;
      end else if (count_en_wr_in) begin
         slice_count_enable_out <= count_en_wdata_in; // RULE_15
      end
   end

   // ==========================================================
   // Slice down counter
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         slice_counter_out <= task_switch_pkg::SLICE_RST;
         timer_running_out <= 1'b0;
      end else begin
         timer_running_out <= count_run;
         if (start_fire) begin
            slice_counter_out <= slice_value_mem[target_task]; // RULE_14
         end else if (slice_wr_in) begin
            slice_counter_out <= slice_wdata_in; // RULE_16
         end else if (count_run && slice_tick) begin
            slice_counter_out <= SLICE_WIDTH'(slice_counter_out - 1'b1); // RULE_09
         end
      end
   end

   // ==========================================================
   // Interrupt context; the task number is left alone so the same task resumes
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         irq_active_out <= 1'b0;
         irq_stack_sel_out <= 1'b0;
      end else if (irq_enter_in) begin
         irq_active_out <= 1'b1; // RULE_05
         irq_stack_sel_out <= 1'b1; // RULE_08
      end else if (irq_return_in) begin
         irq_active_out <= 1'b0; // RULE_05
         irq_stack_sel_out <= 1'b0; // RULE_08
      end
   end

   // ==========================================================
   // Checks
   a_switch_timing: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_19
      switch_start_out |-> ##10 switching_out ##1 saving_out ##4 saving_out ##1 !saving_out)
      else $error("switch or save length wrong");

   a_irq_no_switch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_07
      irq_active_out |-> !switch_start_out)
      else $error("switch started during interrupt");

   a_irq_timer_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_06
      irq_active_out && $past(irq_active_out) && !$past(slice_wr_in) |-> $stable(slice_counter_out))
      else $error("slice timer moved during interrupt");

   a_single_task_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_12
      $onehot($past(task_run_enable_out)) && !$past(slice_wr_in) && !switch_start_out
      |-> $stable(slice_counter_out))
      else $error("slice timer moved with one task");

   a_enable_nonzero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_21
      task_run_enable_out[0] || (task_run_enable_out[TASKS-1:1] != '0))
      else $error("all tasks stopped");

   a_switch_reload: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_14
      switch_start_out && !$past(slice_value_wr_in) |-> slice_counter_out == slice_value_mem[current_task_out])
      else $error("slice timer not loaded on switch");

   a_rotate_order: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_10
      switch_start_out && !by_instr_r
      |-> current_task_out == next_enabled($past(current_task_out), $past(task_run_enable_out)))
      else $error("wrong task after underflow");

   a_instr_target: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_02
      switch_start_out && by_instr_r |-> current_task_out == next_task_select_out)
      else $error("written task not started");

   a_save_ignores: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_01
      saving_out && next_task_wr_in |=> !switch_start_out)
      else $error("write in save window started a switch");

   a_return_pending: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE_17
      irq_active_out && irq_return_in && !irq_enter_in && pend_valid_r && !switching_out && !saving_out
      |-> ##2 switch_start_out)
      else $error("pending switch not launched at return");

endmodule

// >>> rtl/task_switch_pkg.sv
// Shared constants and types for the hardware task switch timer
package task_switch_pkg;

   // ==========================================================
   // Sizes
   localparam int TASK_COUNT = 4;
   localparam int TASK_W = 2;
   localparam int SLICE_W = 8;
   localparam int CYC_W = 4;
   localparam int PRESCALE_W = 5;

   // ==========================================================
   // Sequence lengths in system clock cycles
   localparam int SWITCH_CYCLES = 11;
   localparam int SAVE_CYCLES = 5;

   // ==========================================================
   // Slice clock dividers of the system base clock
   localparam int DIV_FAST = 16;
   localparam int DIV_SLOW = 32;

   // ==========================================================
   // Reset values
   localparam logic [TASK_COUNT-1:0] RUN_ENABLE_RST = 4'h1;
   localparam logic [TASK_W-1:0] TASK_RST = 2'h0;
   localparam logic [SLICE_W-1:0] SLICE_RST = 8'h00;
   localparam logic COUNT_ENABLE_RST = 1'b1;

   // ==========================================================
   // Switch sequencer states, one-hot
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_SWITCH = 3'b010,
      SEQ_SAVE = 3'b100
   } seq_state_t;

endpackage

// >>> rtl/slice_prescaler.sv
// Divides the system base clock by 16 or 32 into a one-cycle slice tick
`timescale 1ns/1ps
module slice_prescaler #(
   parameter int DIV_W = task_switch_pkg::PRESCALE_W
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic div32_sel_in,
   // Tick
   output logic tick_out
);
   logic [DIV_W-1:0] div_cnt_r;
   logic [DIV_W-1:0] div_last;

   assign div_last = div32_sel_in ? DIV_W'(task_switch_pkg::DIV_SLOW - 1)
                                  : DIV_W'(task_switch_pkg::DIV_FAST - 1);

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         div_cnt_r <= '0;
         tick_out <= 1'b0;
      end else if (div_cnt_r >= div_last) begin
         div_cnt_r <= '0;
         tick_out <= 1'b1;
      end else begin
         div_cnt_r <= DIV_W'(div_cnt_r + 1'b1);
         tick_out <= 1'b0;
      end
   end

endmodule

// >>> testbench/cpu_irq_model.sv
// CPU side model that enters and leaves interrupt service
`timescale 1ns/1ps
module cpu_irq_model (
   // Clock
   input wire logic sys_clk_in,
   // Interrupt events
   output logic irq_enter_out,
   output logic irq_return_out
);
   initial begin
      irq_enter_out = 1'b0;
      irq_return_out = 1'b0;
   end

   // ==========================================================
   // Service routine of len cycles; short or long on request
   task automatic service(input int len);
      @(negedge sys_clk_in);
      irq_enter_out = 1'b1;
      @(negedge sys_clk_in);
      irq_enter_out = 1'b0;
      repeat (len) @(negedge sys_clk_in);
      irq_return_out = 1'b1;
      @(negedge sys_clk_in);
      irq_return_out = 1'b0;
   endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the task switch timer
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   // Signals
   localparam int TSK = 0, EN = 1, SL = 2, CEN = 3, SV = 4;
   logic sys_clk_in, rst_n_in, div32_sel_in, slice_wr_in, slice_value_wr_in, count_en_wr_in, count_en_wdata_in;
   logic enable_wr_in, next_task_wr_in, irq_enter_in, irq_return_in, slice_count_enable_out, timer_running_out;
   logic switch_start_out, switching_out, saving_out, irq_active_out, irq_stack_sel_out;
   logic [7:0] slice_wdata_in, slice_value_wdata_in, slice_counter_out, v;
   logic [1:0] slice_value_idx_in, next_task_wdata_in, current_task_out, next_task_select_out, t;
   logic [3:0] enable_wdata_in, task_run_enable_out;
   int n_fail, total_checks, n;

   hw_task_switch_timer DUT (
      .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .div32_sel_in(div32_sel_in),
      .slice_wr_in(slice_wr_in), .slice_wdata_in(slice_wdata_in), .slice_value_wr_in(slice_value_wr_in),
      .slice_value_idx_in(slice_value_idx_in), .slice_value_wdata_in(slice_value_wdata_in),
      .count_en_wr_in(count_en_wr_in), .count_en_wdata_in(count_en_wdata_in), .enable_wr_in(enable_wr_in),
      .enable_wdata_in(enable_wdata_in), .next_task_wr_in(next_task_wr_in),
      .next_task_wdata_in(next_task_wdata_in), .irq_enter_in(irq_enter_in), .irq_return_in(irq_return_in),
      .current_task_out(current_task_out), .task_run_enable_out(task_run_enable_out),
      .slice_count_enable_out(slice_count_enable_out), .next_task_select_out(next_task_select_out),
      .slice_counter_out(slice_counter_out), .timer_running_out(timer_running_out),
      .switch_start_out(switch_start_out), .switching_out(switching_out), .saving_out(saving_out),
      .irq_active_out(irq_active_out), .irq_stack_sel_out(irq_stack_sel_out));

   cpu_irq_model cpu (.sys_clk_in(sys_clk_in), .irq_enter_out(irq_enter_in), .irq_return_out(irq_return_in));

   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end

   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk_in);
   endtask

   // One strobe per call; data lines are shared so one value serves all
   task automatic wr(input int k, input logic [7:0] d);
      @(negedge sys_clk_in);
      slice_wdata_in = d;
      slice_value_wdata_in = d;
      enable_wdata_in = d[3:0];
      next_task_wdata_in = d[1:0];
      count_en_wdata_in = d[0];
      slice_value_idx_in = 2'(k - SV);
      next_task_wr_in = (k == TSK);
      enable_wr_in = (k == EN);
      slice_wr_in = (k == SL);
      count_en_wr_in = (k == CEN);
      slice_value_wr_in = (k >= SV);
      @(negedge sys_clk_in);
      {next_task_wr_in, enable_wr_in, slice_wr_in, count_en_wr_in, slice_value_wr_in} = '0;
   endtask

   task automatic wait_start(input int lim);
      n = 0;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (switch_start_out !== 1'b1 && n < lim);
      chk(switch_start_out, 1);
   endtask

   task automatic wait_cnt(input logic [7:0] val);
      n = 0;
      while (slice_counter_out !== val && n < 3000) begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(slice_counter_out, val);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      chk(current_task_out, 0);
      chk(task_run_enable_out, 4'h1);
      chk(slice_count_enable_out, 1);
      tick(40);
      chk(slice_counter_out, 8'h00);
      chk(timer_running_out, 0);
      chk(current_task_out, 0);
   endtask

   task automatic t_write;
      for (int i = 0; i < 4; i++) wr(SV + i, 8'(8'h02 + i));
      wr(TSK, 8'h02);
      chk(switch_start_out, 1);
      chk(current_task_out, 2);
      chk(slice_counter_out, 8'h04);
      for (n = 0; switching_out === 1'b1 && n < 20; n++) tick(1);
      chk(8'(n), 8'd11);
      for (n = 0; saving_out === 1'b1 && n < 20; n++) tick(1);
      chk(8'(n), 8'd5);
   endtask

   task automatic t_rot;
      wr(SL, 8'h01);
      wr(EN, 8'h0A);
      wait_start(100);
      chk(current_task_out, 3);
      wait_start(200);
      chk(current_task_out, 1);
      chk(slice_counter_out, 8'h03);
      chk(n >= 96 && n <= 116, 1);
      div32_sel_in = 1'b1;
      wait_start(300);
      chk(current_task_out, 3);
      chk(n >= 110 && n <= 150, 1);
      div32_sel_in = 1'b0;
   endtask

   task automatic t_hold(input int k, input logic [7:0] off, input logic [7:0] on);
      wr(k, off);
      tick(2);
      v = slice_counter_out;
      t = current_task_out;
      tick(64);
      chk(slice_counter_out, v);
      chk(timer_running_out, 0);
      chk(slice_count_enable_out, k != CEN);
      chk(current_task_out, t);
      wr(k, on);
      chk(slice_counter_out, v);
      tick(3);
      chk(timer_running_out, 1);
   endtask

   task automatic t_irq;
      wr(SL, 8'h80);
      fork
         cpu.service(60);
         begin
            tick(3);
            chk(irq_active_out, 1);
            chk(irq_stack_sel_out, 1);
            t = current_task_out;
            v = slice_counter_out;
            chk(v, 8'h80);
            wr(TSK, 8'h02);
            chk(switch_start_out, 0);
            chk(next_task_select_out, 2);
            tick(40);
            chk(slice_counter_out, v);
            chk(current_task_out, t);
         end
      join
      chk(irq_active_out, 0);
      chk(irq_stack_sel_out, 0);
      tick(1);
      chk(switch_start_out, 1);
      chk(current_task_out, 2);
      tick(20);
      cpu.service(2);
      tick(3);
      chk(timer_running_out, 1);
   endtask

   task automatic t_merge;
      wr(EN, 8'h0B);
      wait_cnt(8'h01);
      wait_cnt(8'h00);
      tick(14);
      wr(TSK, 8'h02);
      chk(switch_start_out, 1);
      chk(current_task_out, 2);
      n = 0;
      repeat (30) begin
         tick(1);
         n += switch_start_out;
      end
      chk(8'(n), 0);
   endtask

   task automatic t_save;
      wait_start(300);
      chk(current_task_out, 3);
      while (saving_out !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      t = current_task_out;
      {next_task_wdata_in, enable_wdata_in} = {2'h0, 4'hF};
      {next_task_wr_in, enable_wr_in} = 2'b11;
      tick(1);
      {next_task_wr_in, enable_wr_in} = 2'b00;
      chk(task_run_enable_out, 4'hF);
      n = 0;
      repeat (12) begin
         n += switch_start_out;
         tick(1);
      end
      chk(8'(n), 0);
      chk(current_task_out, t);
   endtask

   // ==========================================================
   // Run control
   task automatic results;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk_in);
      n_fail++;
      results();
   end

   initial begin
      {rst_n_in, div32_sel_in, slice_wr_in, slice_value_wr_in, count_en_wr_in, count_en_wdata_in} = '0;
      {enable_wr_in, next_task_wr_in, slice_wdata_in, slice_value_wdata_in} = '0;
      {slice_value_idx_in, next_task_wdata_in, enable_wdata_in} = '0;
      n_fail = 0;
      total_checks = 0;
      tick(16);
      rst_n_in = 1'b1;
      t_reset();
      t_write();
      t_rot();
      t_hold(EN, 8'h08, 8'h0A);
      t_hold(CEN, 8'h00, 8'h01);
      wr(EN, 8'h00);
      chk(task_run_enable_out, 4'h1);
      wr(EN, 8'h0A);
      chk(task_run_enable_out, 4'hA);
      t_irq();
      t_merge();
      t_save();
      results();
   end
endmodule
